// File: pwr_pkg.sv
// shared constants and carrier types for the power-mode supervisor
// assumes a single 20 MHz core clock and a plain register port
package pwr_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FAST_WAKE_NS = 5000;
  localparam int unsigned FAST_WAKE_CYC = (FAST_WAKE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned VREF_SETTLE_CYC_DEF = 2000;
  localparam int unsigned OPT_LOAD_CYC = 16;

  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PERIPH_EN = 4'h1;
  localparam logic [3:0] ADDR_HALT_CFG = 4'h2;
  localparam logic [3:0] ADDR_DET_CTRL = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DET_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_BROWN_CFG = 4'h6;

  localparam int unsigned MC_LP_RUN_REQ = 0;
  localparam int unsigned MC_LP_RUN_EXIT = 1;
  localparam int unsigned MC_LOW_SPEED_SRC = 2;
  localparam int unsigned HC_FAST_WAKE = 0;
  localparam int unsigned HC_VREF_OFF = 1;
  localparam int unsigned DC_ENABLE = 0;
  localparam int unsigned DC_IRQ_FALL = 1;
  localparam int unsigned DC_IRQ_RISE = 2;
  localparam int unsigned DC_LEVEL_LSB = 4;
  localparam int unsigned DF_FALL = 0;
  localparam int unsigned DF_RISE = 1;

  localparam int unsigned N_PERIPH = 8;
  localparam int unsigned N_BROWN_LEVELS = 5;
  localparam int unsigned N_DET_LEVELS = 7;
  localparam logic [7:0] PERIPH_EN_RST = 8'hff;
  localparam logic [2:0] BROWN_LEVEL_RST = 3'h0;
  localparam logic [2:0] DET_LEVEL_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_LP_RUN = 3'b010,
    ST_LP_WAIT = 3'b011,
    ST_ACT_HALT = 3'b100,
    ST_HALT = 3'b101,
    ST_WAKE = 3'b110
  } pmode_t;

  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_WFI = 2'b01,
    SL_WFE = 2'b10,
    SL_HALT = 2'b11
  } sleep_req_t;

  typedef struct packed {
    logic cpu;
    logic [N_PERIPH-1:0] periph;
    logic rtc;
    logic nvm;
    logic low_speed_src;
  } clk_gate_t;

  typedef struct packed {
    logic irq;
    logic ext_irq;
    logic event_in;
    logic rtc_irq;
    logic periph_wake;
  } wake_src_t;

endpackage : pwr_pkg

// File: supply_supervisor.sv
// supply-level and brownout supervision: reset hold, option load, level flags
// assumes comparator inputs already synchronous to core_clk
`timescale 1ns/1ps
module supply_supervisor import pwr_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic supply_above_por,
  input wire logic [N_BROWN_LEVELS-1:0] supply_above_brown,
  input wire logic [N_DET_LEVELS-1:0] supply_above_det,
  input wire logic brown_disable_opt,
  input wire logic [2:0] brown_level_opt,
  input wire logic vref_on,
  input wire logic [2:0] detector_threshold,
  input wire logic det_enable,
  output logic sys_reset_hold_reg,
  output logic opt_loaded_reg,
  output logic [2:0] brown_level_reg,
  output logic brown_active_reg,
  output logic det_above_reg,
  output logic det_fall_pulse_reg,
  output logic det_rise_pulse_reg
);

  logic [4:0] opt_cnt_reg;
  logic brown_ok;
  logic [2:0] det_idx;
  logic det_now;

  // first level is the power-up brownout point; brownout is live before options load
  assign brown_ok = opt_loaded_reg ? supply_above_brown[brown_level_reg]
                                   : supply_above_brown[0];
  assign det_idx = (detector_threshold > 3'h6) ? 3'h6 : detector_threshold;
  assign det_now = supply_above_det[det_idx];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_cnt_reg <= 5'h00;
      opt_loaded_reg <= 1'b0;
      brown_level_reg <= BROWN_LEVEL_RST;
      brown_active_reg <= 1'b1;
    end else if (!supply_above_por) begin
      opt_cnt_reg <= 5'h00;
      opt_loaded_reg <= 1'b0;
      brown_active_reg <= 1'b1;
    end else if (!opt_loaded_reg && supply_above_brown[0]) begin
      // option bytes confirm, change or disable the brownout monitor
      if (opt_cnt_reg == 5'(OPT_LOAD_CYC - 1)) begin
        opt_loaded_reg <= 1'b1;
        brown_level_reg <= (brown_level_opt > 3'h4) ? 3'h4 : brown_level_opt;
        brown_active_reg <= ~brown_disable_opt;
      end else begin
        opt_cnt_reg <= opt_cnt_reg + 5'h01;
      end
    end
  end

  // vref off in halt takes the brownout monitor with it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset_hold_reg <= 1'b1;
    end else begin
      sys_reset_hold_reg <= !supply_above_por || !opt_loaded_reg ||
                            (brown_active_reg && vref_on && !brown_ok);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_above_reg <= 1'b1;
      det_fall_pulse_reg <= 1'b0;
      det_rise_pulse_reg <= 1'b0;
    end else begin
      det_above_reg <= det_enable ? det_now : det_above_reg;
      det_fall_pulse_reg <= det_enable && det_above_reg && !det_now;
      det_rise_pulse_reg <= det_enable && !det_above_reg && det_now;
    end
  end

endmodule : supply_supervisor

// File: power_mode_ctrl.sv
// power-mode sequencer: clock gating, regulator mode, wake routing, register port
// assumes sleep requests from the cpu and wake inputs synchronous to core_clk
//
// What this block does
// - wait mode stops cpu clock, selected peripheral clocks keep running
// - wait exits on interrupt (interrupt-wait) or event (event-wait), or reset
// - low-power run: low-speed clock, ram execution, nvm off, low-power regulator
// - low-power run entered only by software, left by software or reset
// - event-wait in low-power run enters low-power wait, cpu clock stopped
// - low-power wait wakes on peripheral event back to low-power run; reset returns to run
// - active-halt keeps only the rtc clock; wakes on rtc or external interrupt
// - halt stops cpu and peripheral clocks; wakes on ext irq or wake peripheral
// - fast-wake option resumes halt in about 5 us without vref settling
// - brownout monitor active at power-on; options load once above 1.8 V level
// - five brownout thresholds selectable by option bytes
// - optional automatic vref and brownout switch-off while halted
// - reset held while supply below power-on or active brownout level
// - supply-level detector software enabled with seven selectable levels
// - detector interrupt on falling below, rising above, or both
// - main regulator in run, wait and wake; low-power regulator in other modes
// - halt and active-halt switch to low-power regulator automatically
`timescale 1ns/1ps
module power_mode_ctrl import pwr_pkg::*; #(
  parameter int unsigned VREF_SETTLE_CYC = VREF_SETTLE_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sleep_req_t sleep_req,
  input wire logic rtc_sel_halt,
  input wire wake_src_t wake_in,
  input wire logic supply_above_por,
  input wire logic [N_BROWN_LEVELS-1:0] supply_above_brown,
  input wire logic [N_DET_LEVELS-1:0] supply_above_det,
  input wire logic brown_disable_opt,
  input wire logic [2:0] brown_level_opt,
  output clk_gate_t clk_gate,
  output logic main_regulator_mode,
  output logic low_power_regulator_mode,
  output logic vref_on,
  output logic sys_reset_hold,
  output logic det_irq,
  output pmode_t mode_out
);

  pmode_t mode_reg;
  pmode_t mode_next;
  logic [7:0] periph_en_reg;
  logic lp_run_sw_reg;
  logic low_speed_src_reg;
  logic fast_wake_reg;
  logic vref_off_halt_reg;
  logic det_en_reg;
  logic det_irq_fall_en_reg;
  logic det_irq_rise_en_reg;
  logic [2:0] det_level_reg;
  logic [1:0] det_flags_reg;
  logic wait_by_event_reg;
  logic halt_was_active_reg;
  logic [15:0] wake_cnt_reg;
  logic [7:0] rdata_reg;
  clk_gate_t gate_reg;
  logic main_reg_reg;
  logic vref_on_reg;
  logic det_irq_reg;

  logic rst_hold;
  logic opt_loaded;
  logic [2:0] brown_level;
  logic brown_active;
  logic det_above;
  logic det_fall;
  logic det_rise;
  logic wake_hit;
  logic lp_exit_wr;
  logic [15:0] wake_len;

  supply_supervisor u_supply (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .supply_above_por(supply_above_por),
    .supply_above_brown(supply_above_brown),
    .supply_above_det(supply_above_det),
    .brown_disable_opt(brown_disable_opt),
    .brown_level_opt(brown_level_opt),
    .vref_on(vref_on_reg),
    .detector_threshold(det_level_reg),
    .det_enable(det_en_reg),
    .sys_reset_hold_reg(rst_hold),
    .opt_loaded_reg(opt_loaded),
    .brown_level_reg(brown_level),
    .brown_active_reg(brown_active),
    .det_above_reg(det_above),
    .det_fall_pulse_reg(det_fall),
    .det_rise_pulse_reg(det_rise)
  );

  assign lp_exit_wr = reg_wr && (reg_addr == ADDR_MODE_CTRL) && reg_wdata[MC_LP_RUN_EXIT];
  // settle wait is skipped with fast wake; vref only needs settling if it was off
  assign wake_len = (fast_wake_reg || !vref_off_halt_reg) ? 16'(FAST_WAKE_CYC)
                                                           : 16'(VREF_SETTLE_CYC);

  // wake source routing per sleeping mode
  always_comb begin
    wake_hit = 1'b0;
    case (mode_reg)
      ST_WAIT: wake_hit = wait_by_event_reg ? wake_in.event_in
                                            : (wake_in.irq || wake_in.ext_irq);
      ST_LP_WAIT: wake_hit = wake_in.event_in;
      ST_ACT_HALT: wake_hit = wake_in.rtc_irq || wake_in.ext_irq;
      ST_HALT: wake_hit = wake_in.ext_irq || wake_in.periph_wake;
      default: wake_hit = 1'b0;
    endcase
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_RUN: begin
        if (lp_run_sw_reg) begin
          mode_next = ST_LP_RUN;
        end else if (sleep_req == SL_WFI || sleep_req == SL_WFE) begin
          mode_next = ST_WAIT;
        end else if (sleep_req == SL_HALT) begin
          mode_next = rtc_sel_halt ? ST_ACT_HALT : ST_HALT;
        end
      end
      ST_WAIT: begin
        if (wake_hit) begin
          mode_next = ST_RUN;
        end
      end
      ST_LP_RUN: begin
        // interrupts are ignored here; only software or reset leaves
        if (lp_exit_wr || !lp_run_sw_reg) begin
          mode_next = ST_RUN;
        end else if (sleep_req == SL_WFE) begin
          mode_next = ST_LP_WAIT;
        end
      end
      ST_LP_WAIT: begin
        if (wake_hit) begin
          mode_next = ST_LP_RUN;
        end
      end
      ST_ACT_HALT, ST_HALT: begin
        if (wake_hit) begin
          mode_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_cnt_reg >= wake_len - 16'h0001) begin
          mode_next = ST_RUN;
        end
      end
      default: mode_next = ST_RUN;
    endcase
  end

  // supply reset forces run like an external reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= ST_RUN;
      wait_by_event_reg <= 1'b0;
      halt_was_active_reg <= 1'b0;
    end else if (rst_hold) begin
      mode_reg <= ST_RUN;
      wait_by_event_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg == ST_RUN && sleep_req == SL_WFE) begin
        wait_by_event_reg <= 1'b1;
      end else if (mode_reg == ST_RUN && sleep_req == SL_WFI) begin
        wait_by_event_reg <= 1'b0;
      end
      if (mode_next == ST_ACT_HALT || mode_next == ST_HALT) begin
        halt_was_active_reg <= (mode_next == ST_ACT_HALT);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_reg <= 16'h0000;
    end else if (mode_reg == ST_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 16'h0001;
    end else begin
      wake_cnt_reg <= 16'h0000;
    end
  end

  // software control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_run_sw_reg <= 1'b0;
      low_speed_src_reg <= 1'b0;
      periph_en_reg <= PERIPH_EN_RST;
      fast_wake_reg <= 1'b0;
      vref_off_halt_reg <= 1'b0;
      det_en_reg <= 1'b0;
      det_irq_fall_en_reg <= 1'b0;
      det_irq_rise_en_reg <= 1'b0;
      det_level_reg <= DET_LEVEL_RST;
    end else if (rst_hold) begin
      lp_run_sw_reg <= 1'b0;
      periph_en_reg <= PERIPH_EN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE_CTRL: begin
          // request bit sets, exit bit clears; exit wins
          lp_run_sw_reg <= reg_wdata[MC_LP_RUN_REQ] && !reg_wdata[MC_LP_RUN_EXIT];
          low_speed_src_reg <= reg_wdata[MC_LOW_SPEED_SRC];
        end
        ADDR_PERIPH_EN: periph_en_reg <= reg_wdata;
        ADDR_HALT_CFG: begin
          fast_wake_reg <= reg_wdata[HC_FAST_WAKE];
          vref_off_halt_reg <= reg_wdata[HC_VREF_OFF];
        end
        ADDR_DET_CTRL: begin
          det_en_reg <= reg_wdata[DC_ENABLE];
          det_irq_fall_en_reg <= reg_wdata[DC_IRQ_FALL];
          det_irq_rise_en_reg <= reg_wdata[DC_IRQ_RISE];
          det_level_reg <= reg_wdata[DC_LEVEL_LSB +: 3];
        end
        default: begin
        end
      endcase
    end else if (mode_next == ST_RUN && mode_reg == ST_LP_RUN) begin
      lp_run_sw_reg <= 1'b0;
    end
  end

  // detector flags: write one to clear, a new edge in the same cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_flags_reg <= 2'b00;
      det_irq_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == DF_FALL && det_fall) || (i == DF_RISE && det_rise)) begin
          det_flags_reg[i] <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_DET_FLAGS && reg_wdata[i]) begin
          det_flags_reg[i] <= 1'b0;
        end
      end
      det_irq_reg <= (det_flags_reg[DF_FALL] && det_irq_fall_en_reg) ||
                     (det_flags_reg[DF_RISE] && det_irq_rise_en_reg);
    end
  end

  // gates, regulator and vref are all registered from the next mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_reg <= '{cpu: 1'b1, periph: PERIPH_EN_RST, rtc: 1'b1, nvm: 1'b1,
                    low_speed_src: 1'b0};
      main_reg_reg <= 1'b1;
      vref_on_reg <= 1'b1;
    end else begin
      case (mode_next)
        ST_WAIT: begin
          gate_reg <= '{cpu: 1'b0, periph: periph_en_reg, rtc: 1'b1, nvm: 1'b1,
                        low_speed_src: 1'b0};
          main_reg_reg <= 1'b1;
          vref_on_reg <= 1'b1;
        end
        ST_LP_RUN, ST_LP_WAIT: begin
          gate_reg <= '{cpu: (mode_next == ST_LP_RUN), periph: periph_en_reg, rtc: 1'b1,
                        nvm: 1'b0, low_speed_src: 1'b1};
          main_reg_reg <= 1'b0;
          vref_on_reg <= 1'b1;
        end
        ST_ACT_HALT, ST_HALT: begin
          gate_reg <= '{cpu: 1'b0, periph: 8'h00, rtc: (mode_next == ST_ACT_HALT),
                        nvm: 1'b0, low_speed_src: 1'b0};
          main_reg_reg <= 1'b0;
          vref_on_reg <= !vref_off_halt_reg;
        end
        ST_WAKE: begin
          // cpu and peripheral clocks stay off until vref and regulator are back
          gate_reg <= '{cpu: 1'b0, periph: 8'h00, rtc: halt_was_active_reg, nvm: 1'b0,
                        low_speed_src: 1'b0};
          main_reg_reg <= 1'b1;
          vref_on_reg <= 1'b1;
        end
        default: begin
          gate_reg <= '{cpu: 1'b1, periph: periph_en_reg, rtc: 1'b1, nvm: 1'b1,
                        low_speed_src: low_speed_src_reg};
          main_reg_reg <= 1'b1;
          vref_on_reg <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE_CTRL: rdata_reg <= {5'h00, low_speed_src_reg, 1'b0, lp_run_sw_reg};
        ADDR_PERIPH_EN: rdata_reg <= periph_en_reg;
        ADDR_HALT_CFG: rdata_reg <= {6'h00, vref_off_halt_reg, fast_wake_reg};
        ADDR_DET_CTRL: rdata_reg <= {1'b0, det_level_reg, 1'b0, det_irq_rise_en_reg,
                                     det_irq_fall_en_reg, det_en_reg};
        ADDR_STATUS: rdata_reg <= {det_above, brown_active, opt_loaded, rst_hold,
                                   1'b0, mode_reg};
        ADDR_DET_FLAGS: rdata_reg <= {6'h00, det_flags_reg};
        ADDR_BROWN_CFG: rdata_reg <= {5'h00, brown_level};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign clk_gate = gate_reg;
  assign main_regulator_mode = main_reg_reg;
  assign low_power_regulator_mode = !main_reg_reg;
  assign vref_on = vref_on_reg;
  assign sys_reset_hold = rst_hold;
  assign det_irq = det_irq_reg;
  assign mode_out = mode_reg;

endmodule : power_mode_ctrl

// File: power_mode_ctrl_asserts.sv
// assertion checker for power_mode_ctrl, bound at the foot of this file
// assumes only the top ports; halt wake settings are mirrored from bus writes
`timescale 1ns/1ps
module power_mode_ctrl_chk import pwr_pkg::*; #(
  parameter int unsigned VREF_SETTLE_CYC = VREF_SETTLE_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire sleep_req_t sleep_req,
  input wire logic rtc_sel_halt,
  input wire wake_src_t wake_in,
  input wire logic supply_above_por,
  input wire logic [N_BROWN_LEVELS-1:0] supply_above_brown,
  input wire logic [N_DET_LEVELS-1:0] supply_above_det,
  input wire logic brown_disable_opt,
  input wire logic [2:0] brown_level_opt,
  input wire clk_gate_t clk_gate,
  input wire logic main_regulator_mode,
  input wire logic low_power_regulator_mode,
  input wire logic vref_on,
  input wire logic sys_reset_hold,
  input wire logic det_irq,
  input wire pmode_t mode_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic wfi_reg;
  logic fast_reg;
  logic [11:0] wake_cnt_reg;
  // exit sources of wait differ by the instruction that entered it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wfi_reg <= 1'b0;
    else if (mode_out == ST_RUN && sleep_req != SL_IDLE) wfi_reg <= (sleep_req == SL_WFI);
  end
  // long wake only when vref is switched off and fast wake not chosen
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) fast_reg <= 1'b1;
    else if (reg_wr && reg_addr == ADDR_HALT_CFG && !sys_reset_hold)
      fast_reg <= reg_wdata[HC_FAST_WAKE] | ~reg_wdata[HC_VREF_OFF];
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wake_cnt_reg <= 12'h000;
    else wake_cnt_reg <= (mode_out == ST_WAKE) ? wake_cnt_reg + 12'h001 : 12'h000;
  end
  a_wait_cpu_off: assert property (mode_out == ST_WAIT |-> !clk_gate.cpu)
    else $error("cpu clock running in wait");
  a_wfi_exit: assert property (mode_out == ST_WAIT && wfi_reg && !sys_reset_hold &&
    (wake_in.irq || wake_in.ext_irq) |=> mode_out == ST_RUN) else $error("wait missed irq");
  a_wfe_exit: assert property (mode_out == ST_WAIT && !wfi_reg && !sys_reset_hold &&
    wake_in.event_in |=> mode_out == ST_RUN) else $error("wait missed event");
  a_lp_run_gates: assert property (mode_out == ST_LP_RUN |->
    clk_gate.low_speed_src && !clk_gate.nvm && clk_gate.cpu) else $error("lp-run gates");
  a_lp_run_stays: assert property (mode_out == ST_LP_RUN && !reg_wr && !$past(reg_wr) &&
    !sys_reset_hold |=> mode_out inside {ST_LP_RUN, ST_LP_WAIT}) else $error("lp-run left");
  a_lp_wait_off: assert property (mode_out == ST_LP_WAIT |-> !clk_gate.cpu)
    else $error("cpu clock running in lp-wait");
  a_lp_wait_event: assert property (mode_out == ST_LP_WAIT && wake_in.event_in &&
    !sys_reset_hold |=> mode_out == ST_LP_RUN) else $error("lp-wait missed event");
  a_act_halt_rtc: assert property (mode_out == ST_ACT_HALT |-> clk_gate.rtc &&
    !clk_gate.cpu && clk_gate.periph == 8'h00) else $error("active-halt gates");
  a_halt_gates: assert property (mode_out == ST_HALT |-> !clk_gate.rtc &&
    !clk_gate.cpu && clk_gate.periph == 8'h00) else $error("halt gates");
  a_wake_length: assert property (mode_out == ST_WAKE ##1 mode_out != ST_WAKE |->
    wake_cnt_reg == (fast_reg ? FAST_WAKE_CYC : VREF_SETTLE_CYC)) else $error("wake length");
  a_regulator_sel: assert property (low_power_regulator_mode != main_regulator_mode &&
    main_regulator_mode == (mode_out inside {ST_RUN, ST_WAIT, ST_WAKE})) else $error("regulator");
  a_por_hold: assert property (!supply_above_por |-> ##[1:2] sys_reset_hold)
    else $error("reset not held at low supply");
  a_hold_run: assert property (sys_reset_hold |=> mode_out == ST_RUN)
    else $error("mode not run while held");
endmodule : power_mode_ctrl_chk

bind power_mode_ctrl power_mode_ctrl_chk #(.VREF_SETTLE_CYC(VREF_SETTLE_CYC)) chk_i (
  .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_req,
  .rtc_sel_halt, .wake_in, .supply_above_por, .supply_above_brown, .supply_above_det,
  .brown_disable_opt, .brown_level_opt, .clk_gate, .main_regulator_mode,
  .low_power_regulator_mode, .vref_on, .sys_reset_hold, .det_irq, .mode_out);

// File: cpu_wake_model.sv
// cpu-side model: sleep instruction pulses and wake source pulses
// assumes the bench calls its tasks; outputs move just after a rising edge
`timescale 1ns/1ps
module cpu_wake_model import pwr_pkg::*; (
  input wire logic core_clk,
  input wire pmode_t mode_out,
  output sleep_req_t sleep_req,
  output wake_src_t wake_in
);
  initial begin
    sleep_req = SL_IDLE;
    wake_in = '0;
  end
  task automatic sleep(input sleep_req_t k);
    @(posedge core_clk);
    sleep_req <= k;
    @(posedge core_clk);
    sleep_req <= SL_IDLE;
  endtask : sleep
  task automatic wake(input wake_src_t w);
    @(posedge core_clk);
    // software keeps core interrupts masked in both low-power run modes
    if (mode_out == ST_LP_RUN || mode_out == ST_LP_WAIT) w.irq = 1'b0;
    wake_in <= w;
    @(posedge core_clk);
    wake_in <= '0;
  endtask : wake
endmodule : cpu_wake_model

// File: power_mode_ctrl_tb.sv
// self-checking bench for the power-mode sequencer
// assumes the checker is bound in and the cpu model drives sleep and wake
`timescale 1ns/1ps
module power_mode_ctrl_tb import pwr_pkg::*;;
  localparam int unsigned SETTLE = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rtc_sel_halt = 1'b0;
  logic supply_above_por = 1'b0;
  logic [4:0] supply_above_brown = 5'h00;
  logic [6:0] supply_above_det = 7'h7f;
  logic brown_disable_opt = 1'b0;
  logic [2:0] brown_level_opt = 3'h2;
  logic [7:0] reg_rdata, rd_val;
  logic main_regulator_mode, low_power_regulator_mode, vref_on, sys_reset_hold, det_irq;
  sleep_req_t sleep_req;
  wake_src_t wake_in;
  clk_gate_t clk_gate;
  pmode_t mode_out;
  int num_errors = 0;
  int checked = 0;

  always #25 core_clk = ~core_clk;

  cpu_wake_model cpu (.core_clk, .mode_out, .sleep_req, .wake_in);
  power_mode_ctrl #(.VREF_SETTLE_CYC(SETTLE)) dut (
    .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_req,
    .rtc_sel_halt, .wake_in, .supply_above_por, .supply_above_brown, .supply_above_det,
    .brown_disable_opt, .brown_level_opt, .clk_gate, .main_regulator_mode,
    .low_power_regulator_mode, .vref_on, .sys_reset_hold, .det_irq, .mode_out);

  task automatic summarize();
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic wait_mode(input pmode_t m);
    #1;
    for (int i = 0; i < 8 && mode_out !== m; i++) tick(1);
    chk(16'(mode_out), 16'(m));
  endtask : wait_mode
  task automatic wait_release();
    for (int i = 0; i < 60 && sys_reset_hold !== 1'b0; i++) tick(1);
    chk(16'(sys_reset_hold), 16'h0);
  endtask : wait_release
  task automatic t_power_up();
    @(posedge core_clk);
    supply_above_por <= 1'b1;
    tick(30);
    chk(16'(sys_reset_hold), 16'h1);
    @(posedge core_clk);
    supply_above_brown <= 5'h1f;
    tick(8);
    chk(16'(sys_reset_hold), 16'h1);
    wait_release();
    rd(ADDR_BROWN_CFG);
    chk(16'(rd_val), 16'h2);
    rd(ADDR_STATUS);
    chk(16'(rd_val[6:0]), 16'h60);
    rd(4'hf);
    chk(16'(rd_val), 16'h0);
  endtask : t_power_up
  task automatic t_wait();
    wr(ADDR_PERIPH_EN, 8'h5a);
    cpu.sleep(SL_WFI);
    wait_mode(ST_WAIT);
    chk(16'({clk_gate.cpu, clk_gate.periph, main_regulator_mode}), 16'h0b5);
    cpu.wake(5'h04);
    tick(3);
    chk(16'(mode_out), 16'(ST_WAIT));
    cpu.wake(5'h10);
    wait_mode(ST_RUN);
    cpu.sleep(SL_WFE);
    wait_mode(ST_WAIT);
    cpu.wake(5'h04);
    wait_mode(ST_RUN);
  endtask : t_wait
  task automatic t_low_power_run();
    wr(ADDR_MODE_CTRL, 8'h01);
    wait_mode(ST_LP_RUN);
    chk(16'({clk_gate.cpu, clk_gate.nvm, clk_gate.low_speed_src}), 16'h5);
    chk(16'(low_power_regulator_mode), 16'h1);
    cpu.wake(5'h18);
    tick(3);
    chk(16'(mode_out), 16'(ST_LP_RUN));
    cpu.sleep(SL_WFE);
    wait_mode(ST_LP_WAIT);
    chk(16'(clk_gate.cpu), 16'h0);
    cpu.wake(5'h04);
    wait_mode(ST_LP_RUN);
    wr(ADDR_MODE_CTRL, 8'h02);
    wait_mode(ST_RUN);
  endtask : t_low_power_run
  task automatic halt_trip(input logic rtc, input logic [4:0] w, input logic v, input int exp);
    int n;
    @(posedge core_clk);
    rtc_sel_halt <= rtc;
    cpu.sleep(SL_HALT);
    wait_mode(rtc ? ST_ACT_HALT : ST_HALT);
    chk(16'({clk_gate.cpu, clk_gate.periph, clk_gate.rtc, low_power_regulator_mode}),
      {14'h0, rtc, 1'b1});
    cpu.wake(5'h10);
    tick(3);
    chk(16'(mode_out), 16'(rtc ? ST_ACT_HALT : ST_HALT));
    chk(16'(vref_on), 16'(v));
    cpu.wake(w);
    wait_mode(ST_WAKE);
    for (n = 0; mode_out === ST_WAKE && n < 3000; n++) tick(1);
    chk(16'(n), 16'(exp));
    chk(16'(mode_out), 16'(ST_RUN));
  endtask : halt_trip
  task automatic t_halt();
    halt_trip(1'b1, 5'h02, 1'b1, FAST_WAKE_CYC);
    wr(ADDR_HALT_CFG, 8'h02);
    halt_trip(1'b0, 5'h01, 1'b0, SETTLE);
    wr(ADDR_HALT_CFG, 8'h03);
    halt_trip(1'b0, 5'h08, 1'b0, FAST_WAKE_CYC);
  endtask : t_halt
  task automatic set_det(logic [6:0] v);
    @(posedge core_clk);
    supply_above_det <= v;
    tick(4);
  endtask : set_det
  task automatic t_detector();
    for (int lv = 0; lv < N_DET_LEVELS; lv++) begin
      wr(ADDR_DET_CTRL, {1'b0, 3'(lv), 4'h3});
      set_det(~(7'h01 << lv));
      chk(16'(det_irq), 16'h1);
      set_det(7'h7f);
      wr(ADDR_DET_FLAGS, 8'h03);
      tick(4);
      chk(16'(det_irq), 16'h0);
    end
    wr(ADDR_DET_CTRL, 8'h35);
    set_det(7'h77);
    chk(16'(det_irq), 16'h0);
    set_det(7'h7f);
    chk(16'(det_irq), 16'h1);
    rd(ADDR_DET_FLAGS);
    chk(16'(rd_val[DF_RISE]), 16'h1);
  endtask : t_detector
  task automatic t_reset_from_lp();
    wr(ADDR_MODE_CTRL, 8'h01);
    wait_mode(ST_LP_RUN);
    @(posedge core_clk);
    arst_n <= 1'b0;
    tick(2);
    chk(16'({mode_out, clk_gate, main_regulator_mode}), 16'h1ffd);
    @(posedge core_clk);
    arst_n <= 1'b1;
    wait_release();
    rd(ADDR_PERIPH_EN);
    chk(16'(rd_val), 16'(PERIPH_EN_RST));
    chk(16'(mode_out), 16'(ST_RUN));
    @(posedge core_clk);
    supply_above_por <= 1'b0;
    brown_disable_opt <= 1'b1;
    tick(3);
    chk(16'(sys_reset_hold), 16'h1);
    @(posedge core_clk);
    supply_above_por <= 1'b1;
    wait_release();
    rd(ADDR_STATUS);
    chk(16'(rd_val[6]), 16'h0);
  endtask : t_reset_from_lp

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(clk_gate), 16'hffe);
    chk(16'({sys_reset_hold, main_regulator_mode, vref_on}), 16'h7);
    @(posedge core_clk);
    arst_n <= 1'b1;
    t_power_up();
    t_wait();
    t_low_power_run();
    t_halt();
    t_detector();
    t_reset_from_lp();
    summarize();
  end
  // whole run is about 600 cycles; cut a hang at 6000
  initial begin
    #(50 * 6000);
    num_errors++;
    summarize();
  end
endmodule : power_mode_ctrl_tb
